// ### core/pcs_decoder.sv
`timescale 1ns/10ps

module pcs_decoder
   import pcs_pkg::*;
#(
   parameter int SYNC_STAGES = 2
)
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [7:0]  cfg_wdata,
   output logic [7:0]       cfg_rdata,
   output logic             cfg_hit,
   input  wire logic [15:0] isa_addr,
   input  wire logic        isa_aen,
   input  wire logic        isa_rd_n,
   input  wire logic        isa_wr_n,
   output logic             decode_out_0_n,
   output logic             decode_out_1_n,
   output logic             decode_out_2_n
);

   initial begin
      if (SYNC_STAGES < 2) begin
         $error("pcs_decoder: SYNC_STAGES must be at least 2");
      end
   end

   // Returns 1 when a second-level index names an implemented register.
   function automatic logic pcs_slot_ok(input logic [PCS_IDX_W-1:0] idx);
      logic [1:0] unit;
      unit = idx[PCS_IDX_W-1:PCS_UNIT_POS];
      return (idx[1:0] != PCS_FLD_RSVD) && (int'(unit) < PCS_NUM_OUT);
   endfunction

   logic [PCS_IDX_W-1:0] sel_idx;
   logic [PCS_IDX_W-1:0] next_sel_idx;
   logic [7:0]           base_high      [PCS_NUM_OUT];
   logic [7:0]           base_low       [PCS_NUM_OUT];
   logic [7:0]           decode_cfg     [PCS_NUM_OUT];
   logic [7:0]           next_base_high [PCS_NUM_OUT];
   logic [7:0]           next_base_low  [PCS_NUM_OUT];
   logic [7:0]           next_decode_cfg[PCS_NUM_OUT];
   logic [7:0]           next_cfg_rdata;
   logic [7:0]           slot_data;
   logic [1:0]           sel_unit;
   logic [1:0]           sel_fld;
   logic                 sel_ok;

   assign cfg_hit  = (cfg_addr == PCS_IDX_ADDR) || (cfg_addr == PCS_DATA_ADDR);
   assign sel_unit = sel_idx[PCS_IDX_W-1:PCS_UNIT_POS];
   assign sel_fld  = sel_idx[1:0];
   assign sel_ok   = pcs_slot_ok(sel_idx);

   always_comb begin
      slot_data = PCS_RD_NONE;
      if (sel_ok) begin
         unique case (sel_fld)
            PCS_FLD_HIGH: slot_data = base_high[sel_unit];
            PCS_FLD_LOW:  slot_data = base_low[sel_unit];
            PCS_FLD_CFG:  slot_data = decode_cfg[sel_unit];
            default:      slot_data = PCS_RD_NONE;
         endcase
      end
   end

   always_comb begin
      next_sel_idx    = sel_idx;
      next_base_high  = base_high;
      next_base_low   = base_low;
      next_decode_cfg = decode_cfg;
      next_cfg_rdata  = cfg_rdata;
      if (cfg_wr && (cfg_addr == PCS_IDX_ADDR)) begin
         // Only four bits are stored, so positions 10h-FFh cannot be named.
         next_sel_idx = cfg_wdata[PCS_IDX_W-1:0];
      end
      // Reserved positions ignore writes and read as zero.
      if (cfg_wr && (cfg_addr == PCS_DATA_ADDR) && sel_ok) begin
         unique case (sel_fld)
            PCS_FLD_HIGH: next_base_high[sel_unit]  = cfg_wdata;
            PCS_FLD_LOW:  next_base_low[sel_unit]   = cfg_wdata;
            PCS_FLD_CFG:  next_decode_cfg[sel_unit] = cfg_wdata;
            default:      next_sel_idx = sel_idx;
         endcase
      end
      if (cfg_rd) begin
         if (cfg_addr == PCS_IDX_ADDR) begin
            next_cfg_rdata = {{(8-PCS_IDX_W){1'b0}}, sel_idx};
         end else if (cfg_addr == PCS_DATA_ADDR) begin
            next_cfg_rdata = slot_data;
         end else begin
            next_cfg_rdata = PCS_RD_NONE;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sel_idx   <= '0;
         cfg_rdata <= PCS_RD_NONE;
         for (int i = 0; i < PCS_NUM_OUT; i++) begin
            base_high[i]  <= PCS_REG_RST;
            base_low[i]   <= PCS_REG_RST;
            decode_cfg[i] <= PCS_REG_RST;
         end
      end else if (ce) begin
         sel_idx    <= next_sel_idx;
         cfg_rdata  <= next_cfg_rdata;
         base_high  <= next_base_high;
         base_low   <= next_base_low;
         decode_cfg <= next_decode_cfg;
      end
   end

   // Host pins arrive asynchronously; the first stage feeds only the next stage.
   logic [18:0] pin_sync      [SYNC_STAGES];
   logic [18:0] next_pin_sync [SYNC_STAGES];
   logic [18:0] pin_now;

   always_comb begin
      next_pin_sync[0] = {isa_aen, isa_rd_n, isa_wr_n, isa_addr};
      for (int s = 1; s < SYNC_STAGES; s++) begin
         next_pin_sync[s] = pin_sync[s-1];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int s = 0; s < SYNC_STAGES; s++) begin
            pin_sync[s] <= PCS_PIN_IDLE;
         end
      end else if (ce) begin
         pin_sync <= next_pin_sync;
      end
   end

   assign pin_now = pin_sync[SYNC_STAGES-1];

   logic [PCS_NUM_OUT-1:0] hit;
   logic [PCS_NUM_OUT-1:0] sel_n;
   logic [PCS_NUM_OUT-1:0] next_sel_n;

   generate
      for (genvar g = 0; g < PCS_NUM_OUT; g++) begin : g_out
         pcs_match u_match (
            .host_addr (pin_now[15:0]),
            .host_aen  (pin_now[18]),
            .host_rd_n (pin_now[17]),
            .host_wr_n (pin_now[16]),
            .base      ({base_high[g], base_low[g]}),
            .cfg       (decode_cfg[g]),
            .hit       (hit[g])
         );
      end
   endgenerate

   // Registering costs one cycle but keeps the pins glitch free.
   always_comb begin
      next_sel_n = ~hit;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sel_n <= '1;
      end else if (ce) begin
         sel_n <= next_sel_n;
      end
   end

   assign decode_out_0_n = sel_n[0];
   assign decode_out_1_n = sel_n[1];
   assign decode_out_2_n = sel_n[2];

endmodule // pcs_decoder

// ### core/pcs_pkg.sv
package pcs_pkg;

   // First-level locations of the shared configuration space.
   localparam logic [7:0] PCS_IDX_ADDR  = 8'h23;
   localparam logic [7:0] PCS_DATA_ADDR = 8'h24;

   // Second-level layout: index bits 3..2 pick the output, bits 1..0 the field.
   localparam int         PCS_NUM_OUT    = 3;
   localparam int         PCS_UNIT_POS   = 2;
   localparam int         PCS_IDX_W      = 4;
   localparam logic [1:0] PCS_FLD_HIGH   = 2'h0;
   localparam logic [1:0] PCS_FLD_LOW    = 2'h1;
   localparam logic [1:0] PCS_FLD_CFG    = 2'h2;
   localparam logic [1:0] PCS_FLD_RSVD   = 2'h3;

   // Second-level offsets of each register.
   localparam logic [7:0] PCS_SEL0_BASE_HIGH = 8'h00;
   localparam logic [7:0] PCS_SEL0_BASE_LOW  = 8'h01;
   localparam logic [7:0] PCS_SEL0_CONFIG    = 8'h02;
   localparam logic [7:0] PCS_SEL1_BASE_HIGH = 8'h04;
   localparam logic [7:0] PCS_SEL1_BASE_LOW  = 8'h05;
   localparam logic [7:0] PCS_SEL1_CONFIG    = 8'h06;
   localparam logic [7:0] PCS_SEL2_BASE_HIGH = 8'h08;
   localparam logic [7:0] PCS_SEL2_BASE_LOW  = 8'h09;
   localparam logic [7:0] PCS_SEL2_CONFIG    = 8'h0a;

   // Decode configuration fields.
   localparam int PCS_CFG_LOW_MASK_W = 4;
   localparam int PCS_CFG_WR_BIT     = 4;
   localparam int PCS_CFG_RD_BIT     = 5;
   localparam int PCS_CFG_ANY_BIT    = 6;
   localparam int PCS_CFG_WIDE_BIT   = 7;
   localparam int PCS_WIDE_MASK_W    = 12;
   localparam int PCS_HOST_ADDR_W    = 16;

   // Reset values.
   localparam logic [7:0]  PCS_REG_RST  = 8'h00;
   localparam logic [18:0] PCS_PIN_IDLE = 19'h7_0000;
   localparam logic [7:0]  PCS_RD_NONE  = 8'h00;

endpackage : pcs_pkg

// ### core/pcs_match.sv
`timescale 1ns/10ps

module pcs_match
   import pcs_pkg::*;
(
   input  wire logic [PCS_HOST_ADDR_W-1:0] host_addr,
   input  wire logic                       host_aen,
   input  wire logic                       host_rd_n,
   input  wire logic                       host_wr_n,
   input  wire logic [PCS_HOST_ADDR_W-1:0] base,
   input  wire logic [7:0]                 cfg,
   output logic                            hit
);

   logic [PCS_HOST_ADDR_W-1:0] mask;
   logic                       addr_eq;
   logic                       qual;

   always_comb begin
      // A masked position always matches.
      mask = {{(PCS_HOST_ADDR_W-PCS_WIDE_MASK_W){1'b0}},
              {PCS_WIDE_MASK_W{cfg[PCS_CFG_WIDE_BIT]}}};
      mask[PCS_CFG_LOW_MASK_W-1:0] = mask[PCS_CFG_LOW_MASK_W-1:0]
                                   | cfg[PCS_CFG_LOW_MASK_W-1:0];
      addr_eq = (((host_addr ^ base) & ~mask) == '0);
      qual = cfg[PCS_CFG_ANY_BIT]
           | (cfg[PCS_CFG_RD_BIT] & ~host_rd_n)
           | (cfg[PCS_CFG_WR_BIT] & ~host_wr_n);
      hit = ~host_aen & addr_eq & qual;
   end

endmodule // pcs_match

// ### sim/pcs_decoder_monitor.sv
`timescale 1ns/10ps
module pcs_decoder_monitor #(
   parameter int SYNC_STAGES = 2
)
(
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        ce,
   input wire logic [7:0]  cfg_addr,
   input wire logic        cfg_wr,
   input wire logic        cfg_rd,
   input wire logic [7:0]  cfg_wdata,
   input wire logic [7:0]  cfg_rdata,
   input wire logic        cfg_hit,
   input wire logic [15:0] isa_addr,
   input wire logic        isa_aen,
   input wire logic        isa_rd_n,
   input wire logic        isa_wr_n,
   input wire logic        decode_out_0_n,
   input wire logic        decode_out_1_n,
   input wire logic        decode_out_2_n
);
   logic [2:0] outs;
   assign outs = {decode_out_2_n, decode_out_1_n, decode_out_0_n};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   AST_HIT: assert property (cfg_hit == (cfg_addr == 8'h23 || cfg_addr == 8'h24))
      else $error("config hit wrong");
   AST_RST_RDATA: assert property ($fell(srst) |-> cfg_rdata == 8'h00)
      else $error("read data not cleared by reset");
   AST_RST_OUT: assert property ($fell(srst) |-> outs == 3'h7)
      else $error("select active after reset");
   AST_HOLD: assert property (!cfg_rd |=> $stable(cfg_rdata))
      else $error("read data moved without a read");
   AST_IDX: assert property (ce && cfg_rd && cfg_addr == 8'h23 |=> cfg_rdata[7:4] == 4'h0)
      else $error("index upper bits not zero");
   AST_MISS: assert property (ce && cfg_rd && !cfg_hit |=> cfg_rdata == 8'h00)
      else $error("foreign read returned data");
   // Three samples of a high enable flush the pin synchroniser at the default depth.
   AST_AEN: assert property ((ce && isa_aen) [*3] |=> outs == 3'h7)
      else $error("select active while enable high");
   AST_FREEZE: assert property (!ce |=> $stable(outs) && $stable(cfg_rdata))
      else $error("state moved while clock enable low");
endmodule // pcs_decoder_monitor

bind pcs_decoder pcs_decoder_monitor #(.SYNC_STAGES(SYNC_STAGES)) pcs_decoder_monitor_i (
   .sys_clk(sys_clk), .srst(srst), .ce(ce), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
   .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
   .isa_addr(isa_addr), .isa_aen(isa_aen), .isa_rd_n(isa_rd_n), .isa_wr_n(isa_wr_n),
   .decode_out_0_n(decode_out_0_n), .decode_out_1_n(decode_out_1_n),
   .decode_out_2_n(decode_out_2_n));

// ### sim/pcs_host_model.sv
`timescale 1ns/10ps
module pcs_host_model (
   input  wire logic   sys_clk,
   output logic [15:0] isa_addr,
   output logic        isa_aen,
   output logic        isa_rd_n,
   output logic        isa_wr_n
);
   initial begin
      isa_addr = 16'hffff;
      {isa_aen, isa_rd_n, isa_wr_n} = 3'h7;
   end
   // Pins are the order {enable, read strobe, write strobe}, all changed at one falling edge.
   task automatic cycle(input logic [15:0] addr, input logic [2:0] pins);
      @(negedge sys_clk);
      isa_addr = addr;
      {isa_aen, isa_rd_n, isa_wr_n} = pins;
   endtask
   // A released bus shows the inverse address, so a stale match cannot pass as a real one.
   task automatic idle();
      @(negedge sys_clk);
      isa_addr = ~isa_addr;
      {isa_aen, isa_rd_n, isa_wr_n} = 3'h7;
   endtask
endmodule // pcs_host_model

// ### sim/pcs_decoder_tb.sv
`timescale 1ns/10ps
module pcs_decoder_tb;
   import pcs_pkg::*;
   typedef struct packed {
      logic [1:0]  u;
      logic [7:0]  c;
      logic [15:0] b;
      logic [15:0] a;
      logic [2:0]  p;
      logic        e;
   } pcs_row_t;
   logic        sys_clk, srst, ce, cfg_wr, cfg_rd, cfg_hit, isa_aen, isa_rd_n, isa_wr_n;
   logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
   logic [15:0] isa_addr;
   logic [2:0]  outs;
   pcs_row_t    r;
   int          bad_count, cmp_count;
   pcs_row_t    rows [11] = '{
      '{2'h0, 8'h40, 16'h1234, 16'h1234, 3'h3, 1'b0},
      '{2'h0, 8'h40, 16'h1234, 16'h1234, 3'h7, 1'b1},
      '{2'h1, 8'h10, 16'h0300, 16'h0300, 3'h2, 1'b0},
      '{2'h1, 8'h10, 16'h0300, 16'h0300, 3'h1, 1'b1},
      '{2'h2, 8'h20, 16'h0300, 16'h0300, 3'h1, 1'b0},
      '{2'h2, 8'h20, 16'h0300, 16'h0300, 3'h2, 1'b1},
      '{2'h0, 8'h4f, 16'h0200, 16'h020f, 3'h3, 1'b0},
      '{2'h0, 8'h47, 16'h0200, 16'h0208, 3'h3, 1'b1},
      '{2'h1, 8'hc0, 16'h5000, 16'h5abc, 3'h3, 1'b0},
      '{2'h1, 8'hc0, 16'h5000, 16'h4abc, 3'h3, 1'b1},
      '{2'h2, 8'h00, 16'h0000, 16'h0000, 3'h0, 1'b1}};
   pcs_decoder pcs_decoder_i (.sys_clk(sys_clk), .srst(srst), .ce(ce), .cfg_addr(cfg_addr),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_hit(cfg_hit), .isa_addr(isa_addr), .isa_aen(isa_aen), .isa_rd_n(isa_rd_n),
      .isa_wr_n(isa_wr_n), .decode_out_0_n(outs[0]), .decode_out_1_n(outs[1]),
      .decode_out_2_n(outs[2]));
   pcs_host_model host_i (.sys_clk(sys_clk), .isa_addr(isa_addr), .isa_aen(isa_aen),
      .isa_rd_n(isa_rd_n), .isa_wr_n(isa_wr_n));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cfg_w(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {cfg_addr, cfg_wdata, cfg_wr} = {a, d, 1'b1};
      @(negedge sys_clk);
      cfg_wr = 1'b0;
   endtask
   task automatic cfg_r(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      {cfg_addr, cfg_rd} = {a, 1'b1};
      @(negedge sys_clk);
      cfg_rd = 1'b0;
      check({8'h00, cfg_rdata}, {8'h00, exp});
   endtask
   task automatic reg_r(input logic [7:0] idx, input logic [7:0] exp);
      cfg_w(8'h23, idx);
      cfg_r(8'h24, exp);
   endtask
   task automatic tally_and_finish();
      if (bad_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      {srst, ce, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, bad_count, cmp_count} = '0;
      srst = 1'b1;
      ce = 1'b1;
      repeat (10) @(negedge sys_clk);
      srst = 1'b0;
      check({13'h0000, outs}, 16'h0007);
      for (int i = 0; i < 12; i++) if (i % 4 != 3) reg_r(8'(i), 8'h00);
      foreach (rows[i]) begin
         r = rows[i];
         cfg_w(8'h23, {4'h0, r.u, 2'h0});
         cfg_w(8'h24, r.b[15:8]);
         cfg_w(8'h23, {4'h0, r.u, 2'h1});
         cfg_w(8'h24, r.b[7:0]);
         cfg_w(8'h23, {4'h0, r.u, 2'h2});
         cfg_w(8'h24, r.c);
         reg_r({4'h0, r.u, 2'h0}, r.b[15:8]);
         host_i.cycle(r.a, r.p);
         repeat (4) @(negedge sys_clk);
         check({15'h0000, outs[r.u]}, {15'h0000, r.e});
         host_i.idle();
      end
      cfg_w(8'h23, 8'h19);
      cfg_r(8'h23, 8'h09);
      cfg_w(8'h24, 8'h5a);
      reg_r(8'h09, 8'h5a);
      // The strobe lands on an edge with the enable low, so the write must be lost.
      ce = 1'b0;
      cfg_w(8'h24, 8'h77);
      ce = 1'b1;
      reg_r(8'h09, 8'h5a);
      cfg_r(8'h25, 8'h00);
      srst = 1'b1;
      repeat (10) @(negedge sys_clk);
      srst = 1'b0;
      reg_r(8'h09, 8'h00);
      tally_and_finish();
   end
endmodule // pcs_decoder_tb
